// *** logic/bip_pkg.sv ***
// Constants and types shared by the board interrupt prioritizer.
package bip_pkg;

    // Processor priority levels given to each on-card source.
    localparam logic [2:0] LVL_IDLE = 3'h0;
    localparam logic [2:0] LVL_VSB = 3'h1;
    localparam logic [2:0] LVL_SCC = 3'h2;
    localparam logic [2:0] LVL_SCSI = 3'h4;
    localparam logic [2:0] LVL_CPIO = 3'h6;
    localparam logic [2:0] LVL_PARITY = 3'h7;

    // Autovector for level n is this base plus n; the base itself is the
    // spurious vector, which the board never produces.
    localparam logic [7:0] AUTOVEC_BASE = 8'h18;
    localparam logic [7:0] VECTOR_RST = 8'h00;

    // Suggested vector register contents, used as parameter defaults.
    localparam logic [7:0] SCC1_BASE_DEF = 8'h50;
    localparam logic [7:0] SCC2_BASE_DEF = 8'h51;
    localparam logic [7:0] CPIO_PA_BASE_DEF = 8'h41;
    localparam logic [7:0] CPIO_PB_BASE_DEF = 8'h40;
    localparam logic [7:0] CPIO_CT_BASE_DEF = 8'h60;

    // Request counts per source group.
    localparam int CPIO_N = 5;
    localparam int SCC_N = 12;
    localparam int SCC_PER_PORT = 3;
    localparam int SCC1_PORTS = 2;
    localparam int VME_N = 7;

    // Counter/parallel-I/O request bit positions, highest rank on top.
    localparam logic [3:0] CPIO_T3 = 4'h4;
    localparam logic [3:0] CPIO_PA = 4'h3;
    localparam logic [3:0] CPIO_T2 = 4'h2;
    localparam logic [3:0] CPIO_PB = 4'h1;
    localparam logic [3:0] CPIO_T1 = 4'h0;

    // Cause codes placed in the middle vector bits.
    localparam logic [2:0] CT_CAUSE_T3 = 3'h0;
    localparam logic [2:0] CT_CAUSE_T2 = 3'h1;
    localparam logic [2:0] CT_CAUSE_T1 = 3'h2;
    localparam logic [2:0] SCC_CAUSE_RX = 3'h2;
    localparam logic [2:0] SCC_CAUSE_TX = 3'h0;
    localparam logic [2:0] SCC_CAUSE_ST = 3'h1;
    localparam logic [2:0] SCC_CAUSE_FIRST = 3'h4;

    typedef enum logic [1:0] {
        BIP_IDLE = 2'h0,
        BIP_SEL = 2'h1,
        BIP_WAIT = 2'h3,
        BIP_HOLD = 2'h2
    } bip_state_t;

endpackage : bip_pkg

// *** logic/bip_sync.sv ***
// Two-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module bip_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_nxt = d_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign q_out = sync_r;
endmodule : bip_sync

// *** logic/bip_top.sv ***
// Board interrupt prioritizer: level encoding and acknowledge steering.
`timescale 1ns/1ps

// How it works
// - On-card level 7 is never masked here; backplane IRQ7 follows its enable.
// - Parity error and ACFAIL autovector at level 7.
// - Counter/PIO unit vectored at level 6, ranked.
// - SCSI autovectors at level 4.
// - Serial controllers vectored at level 2, ranked.
// - VSB autovectors at level 1.
// - Backplane IRQn is level n, vector passed.
// - On-card source beats backplane at same level.
// - Backplane requests gated by unit mask outputs.
// - Vectored sources return cause dependent vectors.
// - Cause varies only middle vector bits.
// - Per source enables reshape effective priority.
// - Watchdog or mapping fault raises bus error.
// - Autovector is 24 plus level, never 24.
module bip_top #(
    parameter logic [7:0] SCC1_BASE = bip_pkg::SCC1_BASE_DEF,
    parameter logic [7:0] SCC2_BASE = bip_pkg::SCC2_BASE_DEF,
    parameter logic [7:0] CPIO_PA_BASE = bip_pkg::CPIO_PA_BASE_DEF,
    parameter logic [7:0] CPIO_PB_BASE = bip_pkg::CPIO_PB_BASE_DEF,
    parameter logic [7:0] CPIO_CT_BASE = bip_pkg::CPIO_CT_BASE_DEF
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic parity_err_in,
    input wire logic acfail_in,
    input wire logic [bip_pkg::CPIO_N-1:0] cpio_req_in,
    input wire logic [bip_pkg::CPIO_N-1:0] cpio_en_in,
    input wire logic [2:0] cpio_pa_cause_in,
    input wire logic [2:0] cpio_pb_cause_in,
    input wire logic scsi_irq_in,
    input wire logic [bip_pkg::SCC_N-1:0] scc_req_in,
    input wire logic [bip_pkg::SCC_N-1:0] scc_en_in,
    input wire logic vsb_irq_in,
    input wire logic [bip_pkg::VME_N-1:0] vme_irq_n_in,
    input wire logic [bip_pkg::VME_N-1:0] vme_irq_en_in,
    input wire logic vme_vec_ready_in,
    input wire logic [7:0] vme_vector_in,
    input wire logic iack_in,
    input wire logic [2:0] iack_level_in,
    input wire logic watchdog_in,
    input wire logic mmu_fault_in,
    output logic [2:0] int_level_out,
    output logic avec_out,
    output logic [7:0] vector_out,
    output logic vector_valid_out,
    output logic cpio_iack_out,
    output logic scc1_iack_out,
    output logic scc2_iack_out,
    output logic vme_iack_out,
    output logic [2:0] vme_iack_level_out,
    output logic berr_out
);
    localparam int SYNC_W = 2 * bip_pkg::CPIO_N + 6 + 2 * bip_pkg::SCC_N
        + 2 * bip_pkg::VME_N + 8 + 3 + 8;
    logic [SYNC_W-1:0] raw_w;
    logic [SYNC_W-1:0] syn_w;
    logic parity_s;
    logic acfail_s;
    logic [bip_pkg::CPIO_N-1:0] cpio_req_s;
    logic [bip_pkg::CPIO_N-1:0] cpio_en_s;
    logic [2:0] pa_cause_s;
    logic [2:0] pb_cause_s;
    logic scsi_s;
    logic [bip_pkg::SCC_N-1:0] scc_req_s;
    logic [bip_pkg::SCC_N-1:0] scc_en_s;
    logic vsb_s;
    logic [bip_pkg::VME_N-1:0] vme_irq_n_s;
    logic [bip_pkg::VME_N-1:0] vme_en_s;
    logic vme_ready_s;
    logic [7:0] vme_vector_s;
    logic iack_s;
    logic [2:0] iack_lvl_s;
    logic wdog_s;
    logic mmu_s;
    // Every processor-side and source-side signal is off-domain.
    assign raw_w = {parity_err_in, acfail_in, cpio_req_in, cpio_en_in,
                    cpio_pa_cause_in, cpio_pb_cause_in, scsi_irq_in,
                    scc_req_in, scc_en_in, vsb_irq_in, vme_irq_n_in,
                    vme_irq_en_in, vme_vec_ready_in, vme_vector_in,
                    iack_in, iack_level_in, watchdog_in, mmu_fault_in};
    bip_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .d_in(raw_w),
        .q_out(syn_w)
    );
    assign {parity_s, acfail_s, cpio_req_s, cpio_en_s, pa_cause_s,
            pb_cause_s, scsi_s, scc_req_s, scc_en_s, vsb_s, vme_irq_n_s,
            vme_en_s, vme_ready_s, vme_vector_s, iack_s, iack_lvl_s,
            wdog_s, mmu_s} = syn_w;
    // Index of the highest set bit; bit 0 when nothing is set.
    function automatic logic [3:0] top_idx(input logic [15:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : top_idx
    logic [bip_pkg::CPIO_N-1:0] cpio_act;
    logic [bip_pkg::SCC_N-1:0] scc_act;
    logic [7:0] onc_w;
    logic [7:0] vme_act;
    logic [7:0] pend_w;
    assign cpio_act = cpio_req_s & cpio_en_s;
    assign scc_act = scc_req_s & scc_en_s;
    // Each backplane line is gated by its mask output from the unit.
    assign vme_act[0] = 1'b0;
    for (genvar g = 0; g < bip_pkg::VME_N; g++) begin : g_vme
        assign vme_act[g+1] = ~vme_irq_n_s[g] & vme_en_s[g];
    end
    always_comb begin
        onc_w = 8'h00;
        onc_w[bip_pkg::LVL_PARITY] = parity_s | acfail_s;
        onc_w[bip_pkg::LVL_CPIO] = |cpio_act;
        onc_w[bip_pkg::LVL_SCSI] = scsi_s;
        onc_w[bip_pkg::LVL_SCC] = |scc_act;
        onc_w[bip_pkg::LVL_VSB] = vsb_s;
    end

    // No level mask here: parity and ACFAIL always reach level 7; backplane IRQ7 is gated by its enable.
    assign pend_w = onc_w | vme_act;
    // Vector of the highest ranked counter/parallel-I/O cause.
    logic [3:0] cpio_idx;
    logic [7:0] cpio_vec;
    always_comb begin
        cpio_idx = top_idx(16'(cpio_act));
        case (cpio_idx)
            bip_pkg::CPIO_T3: cpio_vec = {CPIO_CT_BASE[7:4],
                bip_pkg::CT_CAUSE_T3, CPIO_CT_BASE[0]};
            bip_pkg::CPIO_PA: cpio_vec = {CPIO_PA_BASE[7:4],
                pa_cause_s, CPIO_PA_BASE[0]};
            bip_pkg::CPIO_T2: cpio_vec = {CPIO_CT_BASE[7:4],
                bip_pkg::CT_CAUSE_T2, CPIO_CT_BASE[0]};
            bip_pkg::CPIO_PB: cpio_vec = {CPIO_PB_BASE[7:4],
                pb_cause_s, CPIO_PB_BASE[0]};
            default: cpio_vec = {CPIO_CT_BASE[7:4],
                bip_pkg::CT_CAUSE_T1, CPIO_CT_BASE[0]};
        endcase
    end

    // Serial requests run from bit 11 (first port, receive) downward.
    logic [3:0] scc_idx;
    logic [3:0] scc_rel;
    logic [3:0] scc_port;
    logic [3:0] scc_kind;
    logic [2:0] scc_cause;
    logic [7:0] scc_base;
    logic [7:0] scc_vec;
    logic scc_first_ctl;
    always_comb begin
        scc_idx = top_idx(16'(scc_act));
        scc_rel = 4'(bip_pkg::SCC_N - 1) - scc_idx;
        scc_port = 4'(scc_rel / 4'(bip_pkg::SCC_PER_PORT));
        scc_kind = 4'(scc_rel - 4'(scc_port * 4'(bip_pkg::SCC_PER_PORT)));
        scc_first_ctl = scc_port < 4'(bip_pkg::SCC1_PORTS);
        case (scc_kind)
            4'h0: scc_cause = bip_pkg::SCC_CAUSE_RX;
            4'h1: scc_cause = bip_pkg::SCC_CAUSE_TX;
            default: scc_cause = bip_pkg::SCC_CAUSE_ST;
        endcase
        if (!scc_port[0]) begin
            scc_cause = scc_cause | bip_pkg::SCC_CAUSE_FIRST;
        end
        scc_base = scc_first_ctl ? SCC1_BASE : SCC2_BASE;
        scc_vec = {scc_base[7:4], scc_cause, scc_base[0]};
    end
    // Level encoder and bus error, both refreshed every cycle.
    logic [2:0] int_level_r;
    logic [2:0] int_level_nxt;
    logic berr_r;
    logic berr_nxt;
    always_comb begin
        int_level_nxt = bip_pkg::LVL_IDLE;
        if (|pend_w) begin
            int_level_nxt = 3'(top_idx(16'(pend_w)));
        end
        berr_nxt = wdog_s | mmu_s;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            int_level_r <= bip_pkg::LVL_IDLE;
            berr_r <= 1'b0;
        end else begin
            int_level_r <= int_level_nxt;
            berr_r <= berr_nxt;
        end
    end

    // Acknowledge sequencer. The level is latched on entry so that a
    // source changing mid-cycle cannot redirect the acknowledge.
    bip_pkg::bip_state_t state_r;
    bip_pkg::bip_state_t state_nxt;
    logic [2:0] ack_lvl_r;
    logic [2:0] ack_lvl_nxt;
    logic avec_r;
    logic avec_nxt;
    logic [7:0] vector_r;
    logic [7:0] vector_nxt;
    logic valid_r;
    logic valid_nxt;
    logic cpio_iack_r;
    logic cpio_iack_nxt;
    logic scc1_iack_r;
    logic scc1_iack_nxt;
    logic scc2_iack_r;
    logic scc2_iack_nxt;
    logic vme_iack_r;
    logic vme_iack_nxt;
    logic [2:0] vme_lvl_r;
    logic [2:0] vme_lvl_nxt;
    logic is_avec;
    assign is_avec = (ack_lvl_r == bip_pkg::LVL_PARITY)
        || (ack_lvl_r == bip_pkg::LVL_SCSI)
        || (ack_lvl_r == bip_pkg::LVL_VSB);
    always_comb begin
        state_nxt = state_r;
        ack_lvl_nxt = ack_lvl_r;
        avec_nxt = avec_r;
        vector_nxt = vector_r;
        valid_nxt = valid_r;
        cpio_iack_nxt = cpio_iack_r;
        scc1_iack_nxt = scc1_iack_r;
        scc2_iack_nxt = scc2_iack_r;
        vme_iack_nxt = vme_iack_r;
        vme_lvl_nxt = vme_lvl_r;
        case (state_r)
            bip_pkg::BIP_IDLE: begin
                if (iack_s) begin
                    ack_lvl_nxt = iack_lvl_s;
                    state_nxt = bip_pkg::BIP_SEL;
                end
            end
            bip_pkg::BIP_SEL: begin
                state_nxt = bip_pkg::BIP_HOLD;
                valid_nxt = 1'b1;
                if (!iack_s) begin
                    valid_nxt = 1'b0;
                    state_nxt = bip_pkg::BIP_IDLE;
                end else if (onc_w[ack_lvl_r] && is_avec) begin
                    avec_nxt = 1'b1;
                    vector_nxt = 8'(bip_pkg::AUTOVEC_BASE
                        + {5'h00, ack_lvl_r});
                end else if (onc_w[ack_lvl_r]
                             && ack_lvl_r == bip_pkg::LVL_CPIO) begin
                    cpio_iack_nxt = 1'b1;
                    vector_nxt = cpio_vec;
                end else if (onc_w[ack_lvl_r]
                             && ack_lvl_r == bip_pkg::LVL_SCC) begin
                    scc1_iack_nxt = scc_first_ctl;
                    scc2_iack_nxt = !scc_first_ctl;
                    vector_nxt = scc_vec;
                end else begin
                    // Unclaimed levels go to the backplane; a missing
                    // interrupter ends in a watchdog bus error.
                    valid_nxt = 1'b0;
                    vme_iack_nxt = 1'b1;
                    vme_lvl_nxt = ack_lvl_r;
                    state_nxt = bip_pkg::BIP_WAIT;
                end
            end
            bip_pkg::BIP_WAIT: begin
                if (!iack_s) begin
                    vme_iack_nxt = 1'b0;
                    state_nxt = bip_pkg::BIP_IDLE;
                end else if (vme_ready_s) begin
                    vector_nxt = vme_vector_s;
                    valid_nxt = 1'b1;
                    state_nxt = bip_pkg::BIP_HOLD;
                end
            end
            default: begin
                if (!iack_s) begin
                    avec_nxt = 1'b0;
                    valid_nxt = 1'b0;
                    cpio_iack_nxt = 1'b0;
                    scc1_iack_nxt = 1'b0;
                    scc2_iack_nxt = 1'b0;
                    vme_iack_nxt = 1'b0;
                    state_nxt = bip_pkg::BIP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state_r <= bip_pkg::BIP_IDLE;
            ack_lvl_r <= bip_pkg::LVL_IDLE;
            avec_r <= 1'b0;
            vector_r <= bip_pkg::VECTOR_RST;
            valid_r <= 1'b0;
            cpio_iack_r <= 1'b0;
            scc1_iack_r <= 1'b0;
            scc2_iack_r <= 1'b0;
            vme_iack_r <= 1'b0;
            vme_lvl_r <= bip_pkg::LVL_IDLE;
        end else begin
            state_r <= state_nxt;
            ack_lvl_r <= ack_lvl_nxt;
            avec_r <= avec_nxt;
            vector_r <= vector_nxt;
            valid_r <= valid_nxt;
            cpio_iack_r <= cpio_iack_nxt;
            scc1_iack_r <= scc1_iack_nxt;
            scc2_iack_r <= scc2_iack_nxt;
            vme_iack_r <= vme_iack_nxt;
            vme_lvl_r <= vme_lvl_nxt;
        end
    end

    assign int_level_out = int_level_r;
    assign berr_out = berr_r;
    assign avec_out = avec_r;
    assign vector_out = vector_r;
    assign vector_valid_out = valid_r;
    assign cpio_iack_out = cpio_iack_r;
    assign scc1_iack_out = scc1_iack_r;
    assign scc2_iack_out = scc2_iack_r;
    assign vme_iack_out = vme_iack_r;
    assign vme_iack_level_out = vme_lvl_r;
endmodule : bip_top

// *** dv/bip_top_monitor.sv ***
// Concurrent checks on the ports of the board interrupt prioritizer.
`timescale 1ns/1ps
module bip_monitor (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic parity_err_in,
    input wire logic acfail_in,
    input wire logic [4:0] cpio_req_in,
    input wire logic [4:0] cpio_en_in,
    input wire logic scsi_irq_in,
    input wire logic [11:0] scc_req_in,
    input wire logic [11:0] scc_en_in,
    input wire logic vsb_irq_in,
    input wire logic [6:0] vme_irq_n_in,
    input wire logic [6:0] vme_irq_en_in,
    input wire logic [7:0] vme_vector_in,
    input wire logic iack_in,
    input wire logic [2:0] iack_level_in,
    input wire logic watchdog_in,
    input wire logic mmu_fault_in,
    input wire logic [2:0] int_level_out,
    input wire logic avec_out,
    input wire logic [7:0] vector_out,
    input wire logic vector_valid_out,
    input wire logic cpio_iack_out,
    input wire logic scc1_iack_out,
    input wire logic scc2_iack_out,
    input wire logic vme_iack_out,
    input wire logic [2:0] vme_iack_level_out,
    input wire logic berr_out
);
    logic [2:0] up_r;
    logic [2:0] up_nxt;
    logic [2:0] lvl_c;
    logic [7:1] pend;
    logic [6:0] vq;
    logic any_ack;
    logic ok;
    // The ok-gated checks (level, bus error, acknowledge timing) wait until the input synchronisers hold only post-reset data.
    always_comb begin
        vq = ~vme_irq_n_in & vme_irq_en_in;
        pend = {parity_err_in | acfail_in | vq[6],
            |(cpio_req_in & cpio_en_in) | vq[5], vq[4],
            scsi_irq_in | vq[3], vq[2],
            |(scc_req_in & scc_en_in) | vq[1], vsb_irq_in | vq[0]};
        lvl_c = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (pend[i]) begin
                lvl_c = 3'(i);
            end
        end
        up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
        any_ack = avec_out | cpio_iack_out | scc1_iack_out;
        any_ack = any_ack | scc2_iack_out | vme_iack_out;
        ok = (up_r == 3'h7);
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            up_r <= 3'h0;
        end else begin
            up_r <= up_nxt;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    property p_enc;
        ok |-> int_level_out == $past(lvl_c, 3);
    endproperty
    a_enc: assert property (p_enc)
        else $error("level code does not follow inputs");
    property p_lvl7;
        ok && $past(parity_err_in | acfail_in | vq[6], 3)
            |-> int_level_out == 3'h7;
    endproperty
    a_lvl7: assert property (p_lvl7)
        else $error("level seven request lost");
    property p_berr;
        ok |-> berr_out == $past(watchdog_in | mmu_fault_in, 3);
    endproperty
    a_berr: assert property (p_berr)
        else $error("bus error does not follow its causes");
    property p_avec;
        $rose(avec_out) |-> vector_valid_out &&
            vector_out == bip_pkg::AUTOVEC_BASE + {5'h00, iack_level_in};
    endproperty
    a_avec: assert property (p_avec)
        else $error("autovector number wrong");
    property p_rise;
        ok && $rose(iack_in) |-> (!any_ack) [*3] ##2 any_ack;
    endproperty
    a_rise: assert property (p_rise)
        else $error("acknowledge not steered in time");
    property p_clear;
        ok && $fell(iack_in) |-> ##3 !(any_ack | vector_valid_out);
    endproperty
    a_clear: assert property (p_clear)
        else $error("acknowledge outputs not cleared");
    property p_vme_vec;
        $rose(vector_valid_out) && vme_iack_out |->
            vector_out == vme_vector_in;
    endproperty
    a_vme_vec: assert property (p_vme_vec)
        else $error("backplane vector not passed on");
    property p_vme_lvl;
        $rose(vme_iack_out) |-> vme_iack_level_out == iack_level_in;
    endproperty
    a_vme_lvl: assert property (p_vme_lvl)
        else $error("backplane acknowledge level wrong");
    property p_cpio;
        $rose(cpio_iack_out) |-> vector_valid_out
            && iack_level_in == bip_pkg::LVL_CPIO;
    endproperty
    a_cpio: assert property (p_cpio)
        else $error("unit acknowledge at wrong level");
    property p_scc;
        $rose(scc1_iack_out | scc2_iack_out) |->
            !(scc1_iack_out && scc2_iack_out) && vector_valid_out
            && iack_level_in == bip_pkg::LVL_SCC
            && vector_out[0] == (scc1_iack_out ?
            bip_pkg::SCC1_BASE_DEF[0] : bip_pkg::SCC2_BASE_DEF[0]);
    endproperty
    a_scc: assert property (p_scc)
        else $error("serial acknowledge steered wrong");
endmodule : bip_monitor

bind bip_top bip_monitor u_mon (.*);

// *** dv/bip_cpu_model.sv ***
// Processor core and backplane interrupter facing the prioritizer.
`timescale 1ns/1ps
module bip_cpu_model #(
    parameter logic [2:0] MASK = 3'h0
) (
    input wire logic clk_in,
    input wire logic run_in,
    input wire logic slow_in,
    input wire logic [2:0] int_level_in,
    input wire logic vector_valid_in,
    input wire logic [7:0] vector_in,
    input wire logic vme_iack_in,
    input wire logic [7:0] vme_vec_in,
    output logic iack_out,
    output logic [2:0] iack_level_out,
    output logic vme_ready_out,
    output logic [7:0] vme_vector_out,
    output logic [7:0] got_out,
    output logic done_out
);
    int cnt;
    initial begin
        iack_out = 1'b0;
        iack_level_out = 3'h0;
        vme_ready_out = 1'b0;
        vme_vector_out = 8'h00;
        got_out = 8'h00;
        done_out = 1'b0;
        cnt = 0;
    end
    // The bench gates acknowledges with run_in so a source still visible
    // through the level pipeline is not taken twice.
    always @(negedge clk_in) begin
        if (!iack_out && !done_out && run_in &&
            (int_level_in > MASK || int_level_in == 3'h7)) begin
            iack_out <= 1'b1;
            iack_level_out <= int_level_in;
        end else if (iack_out && vector_valid_in) begin
            got_out <= vector_in;
            iack_out <= 1'b0;
            done_out <= 1'b1;
        end else if (!run_in) begin
            done_out <= 1'b0;
        end
        // A released vector bus shows a changing pattern, not stale data.
        if (!vme_iack_in) begin
            cnt <= 0;
            vme_ready_out <= 1'b0;
            vme_vector_out <= ~vme_vector_out;
        end else if (cnt == (slow_in ? 20 : 0)) begin
            vme_ready_out <= 1'b1;
            vme_vector_out <= vme_vec_in;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : bip_cpu_model

// *** dv/tb_top.sv ***
// Self-checking testbench for the board interrupt prioritizer.
`timescale 1ns/1ps
module tb_top;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic parity_err_in, acfail_in, scsi_irq_in, vsb_irq_in;
    logic watchdog_in, mmu_fault_in, iack_in, vme_vec_ready_in;
    logic [4:0] cpio_req_in, cpio_en_in;
    logic [2:0] cpio_pa_cause_in, cpio_pb_cause_in, iack_level_in;
    logic [11:0] scc_req_in, scc_en_in;
    logic [6:0] vme_irq_n_in, vme_irq_en_in;
    logic [2:0] int_level_out, vme_iack_level_out;
    logic avec_out, vector_valid_out, cpio_iack_out, scc1_iack_out;
    logic scc2_iack_out, vme_iack_out, berr_out, run, slow, done;
    logic [7:0] vme_vector_in, vector_out, got, vme_v;
    int error_cnt = 0;
    int check_count = 0;

    bip_top #(
        .SCC1_BASE(8'h50),
        .SCC2_BASE(8'h51),
        .CPIO_PA_BASE(8'h41),
        .CPIO_PB_BASE(8'h40),
        .CPIO_CT_BASE(8'h60)
    ) uut (.*);
    bip_cpu_model u_cpu (.clk_in, .run_in(run), .slow_in(slow),
        .int_level_in(int_level_out), .vector_valid_in(vector_valid_out),
        .vector_in(vector_out), .vme_iack_in(vme_iack_out),
        .vme_vec_in(vme_v), .iack_out(iack_in),
        .iack_level_out(iack_level_in), .vme_ready_out(vme_vec_ready_in),
        .vme_vector_out(vme_vector_in), .got_out(got), .done_out(done));

    always #50 clk_in = ~clk_in;

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task test_done;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    task clr;
        {parity_err_in, acfail_in, scsi_irq_in, vsb_irq_in} = 4'h0;
        {watchdog_in, mmu_fault_in, cpio_pa_cause_in} = 5'h00;
        {cpio_req_in, scc_req_in, cpio_pb_cause_in} = 20'h0_0000;
        {cpio_en_in, scc_en_in} = 17'h1_ffff;
        {vme_irq_n_in, vme_irq_en_in} = 14'h3fff;
    endtask : clr

    // Lets the level settle, has the processor take the vector, clears up.
    task go(input logic [2:0] lv, input logic [7:0] vec);
        int n;
        repeat (4) @(negedge clk_in);
        chk("level", {5'h00, lv}, {5'h00, int_level_out});
        run = 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 100) begin
            @(negedge clk_in);
            n++;
        end
        chk("ack done", 8'h01, {7'h00, done});
        chk("vector", vec, got);
        run = 1'b0;
        clr();
        repeat (6) @(negedge clk_in);
    endtask : go

    task t_auto;
        parity_err_in = 1'b1;
        go(3'h7, 8'h1f);
        chk("table offset", 8'h7c, 8'({got, 2'b00}));
        acfail_in = 1'b1;
        go(3'h7, 8'h1f);
        scsi_irq_in = 1'b1;
        go(3'h4, 8'h1c);
        vsb_irq_in = 1'b1;
        go(3'h1, 8'h19);
    endtask : t_auto

    task t_cpio;
        cpio_req_in = 5'h1f;
        go(3'h6, 8'h60);
        cpio_req_in = 5'h0d;
        cpio_pa_cause_in = 3'h5;
        go(3'h6, 8'h4b);
        cpio_req_in = 5'h05;
        go(3'h6, 8'h62);
        cpio_req_in = 5'h03;
        cpio_pb_cause_in = 3'h3;
        go(3'h6, 8'h46);
        cpio_req_in = 5'h11;
        cpio_en_in = 5'h0f;
        go(3'h6, 8'h64);
    endtask : t_cpio

    task t_scc;
        scc_req_in = 12'h420;
        go(3'h2, 8'h58);
        scc_req_in = 12'h009;
        go(3'h2, 8'h5b);
        scc_req_in = 12'h001;
        go(3'h2, 8'h53);
        scc_req_in = 12'h900;
        scc_en_in = 12'h7ff;
        go(3'h2, 8'h54);
    endtask : t_scc

    task t_vme;
        vme_v = 8'ha5;
        vme_irq_n_in = 7'h6f;
        go(3'h5, 8'ha5);
        slow = 1'b1;
        vme_v = 8'h3c;
        vme_irq_n_in = 7'h7b;
        go(3'h3, 8'h3c);
        slow = 1'b0;
        vme_irq_n_in = 7'h77;
        scsi_irq_in = 1'b1;
        go(3'h4, 8'h1c);
        vme_irq_n_in = 7'h5f;
        cpio_req_in = 5'h01;
        go(3'h6, 8'h64);
        vme_irq_n_in = 7'h3d;
        vme_irq_en_in = 7'h3f;
        go(3'h2, 8'h3c);
        vme_irq_n_in = 7'h00;
        vme_irq_en_in = 7'h00;
        repeat (4) @(negedge clk_in);
        chk("idle level", 8'h00, {5'h00, int_level_out});
        clr();
    endtask : t_vme

    task t_berr;
        watchdog_in = 1'b1;
        repeat (4) @(negedge clk_in);
        chk("berr", 8'h01, {7'h00, berr_out});
        watchdog_in = 1'b0;
        mmu_fault_in = 1'b1;
        repeat (4) @(negedge clk_in);
        chk("berr", 8'h01, {7'h00, berr_out});
        mmu_fault_in = 1'b0;
        repeat (4) @(negedge clk_in);
        chk("berr", 8'h00, {7'h00, berr_out});
    endtask : t_berr

    initial begin
        clr();
        run = 1'b0;
        slow = 1'b0;
        vme_v = 8'h00;
        // Two cycles suffice because vector_r and int_level_r load their reset values on the first clock edge.
        repeat (2) @(negedge clk_in);
        chk("reset vector", 8'h00, vector_out);
        chk("reset level", 8'h00, {5'h00, int_level_out});
        nrst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        t_auto();
        t_cpio();
        t_scc();
        t_vme();
        t_berr();
        test_done();
    end

    initial begin
        repeat (5000) @(posedge clk_in);
        error_cnt++;
        test_done();
    end
endmodule : tb_top
